//--- verilog/ccr_pkg.sv
// constants for the charger configuration register bank
package ccr_pkg;
   // register byte offsets on the register file port
   localparam logic [7:0] ADDR_CHG_VOLT = 8'h26;
   localparam logic [7:0] ADDR_TEMP_VOLT = 8'h27;
   localparam logic [7:0] ADDR_MON_CFG = 8'h28;
   // field positions
   localparam int CV_LSB = 2;
   localparam int CV_MSB = 7;
   localparam int SUSPEND_BIT = 1;
   localparam int SCALE_LSB = 4;
   localparam int SCALE_MSB = 7;
   localparam int SEL_LSB = 0;
   localparam int SEL_MSB = 3;
   // reset values
   localparam logic [5:0] CV_RESET = 6'h00;
   localparam logic [5:0] TEMP_CV_RESET = 6'h00;
   localparam logic SUSPEND_RESET = 1'b0;
   localparam logic [3:0] SCALE_RESET = 4'hF;
   localparam logic [3:0] SEL_RESET = 4'h0;
   // saturation points of the code tables
   localparam logic [5:0] CV_SAT = 6'h28;
   localparam logic [3:0] SCALE_SAT = 4'hA;
   localparam logic [3:0] SCALE_MAX = 4'h9;
   // monitor channel selector codes
   localparam logic [3:0] SEL_OFF = 4'h0;
   localparam logic [3:0] SEL_SYS_FIRST = 4'hA;
   localparam int NUM_CHAN = 10;
   localparam int CHAN_CHG_I = 3;
   // channel order on the one-hot vector
   typedef enum {
      CCR_CH_IN_V, CCR_CH_IN_I, CCR_CH_BATT_V, CCR_CH_CHG_I, CCR_CH_DIS_NORM,
      CCR_CH_DIS_NULL, CCR_CH_THERM, CCR_CH_BIAS, CCR_CH_GND, CCR_CH_SYS
   } ccr_chan_t;
endpackage : ccr_pkg

//--- verilog/ccr_mux_decode.sv
// monitor channel selector decode to a one-hot vector
`timescale 1ns/1ps
module ccr_mux_decode (
   // selector
   input wire logic [3:0] sel,
   // decoded channel enables, none when disabled
   output logic [ccr_pkg::NUM_CHAN-1:0] chan
);
   // codes 1 through 9 each pick one channel
   genvar i;
   generate
      for (i = 0; i < ccr_pkg::NUM_CHAN - 1; i++) begin : g_chan
         assign chan[i] = (sel == 4'(i + 1));
      end
   endgenerate
   // all upper codes fold onto the system voltage channel
   assign chan[ccr_pkg::NUM_CHAN-1] = (sel >= ccr_pkg::SEL_SYS_FIRST);
endmodule : ccr_mux_decode

//--- verilog/ccr_regs.sv
// charger configuration register bank with monitor mux control
`timescale 1ns/1ps
module ccr_regs (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // register file port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // status from the analog side and the on/off controller
   input wire logic temp_normal,
   input wire logic charging_flag,
   input wire logic resource_on,
   // charger controls
   output logic [5:0] battery_target_voltage_code,
   output logic input_suspend,
   output logic input_draw_en,
   output logic input_change_irq,
   output logic input_detail_clear,
   output logic [3:0] discharge_monitor_full_scale,
   // monitor multiplexer controls
   output logic [ccr_pkg::NUM_CHAN-1:0] monitor_chan_en,
   output logic monitor_output_oe_n,
   output logic monitor_chg_valid
);
   logic [5:0] cv_q, cv_d, tcv_q, tcv_d;
   logic susp_q, susp_d;
   logic [3:0] scale_q, scale_d, sel_q, sel_d;
   logic [2:0] sync1_q, sync2_q;
   logic [7:0] rdata_q, rdata_d;
   logic [5:0] eff_cv_q;
   logic irq_q, draw_q, det_q;
   logic [3:0] scale_eff_q;
   logic [ccr_pkg::NUM_CHAN-1:0] chan_q;
   logic oe_n_q, chg_valid_q;

   // write and read decode
   wire wr_volt = reg_wr && (reg_addr == ccr_pkg::ADDR_CHG_VOLT);
   wire wr_temp = reg_wr && (reg_addr == ccr_pkg::ADDR_TEMP_VOLT);
   wire wr_mon = reg_wr && (reg_addr == ccr_pkg::ADDR_MON_CFG);
   wire temp_norm_s = sync2_q[0];
   wire charging_s = sync2_q[1];
   wire res_on_s = sync2_q[2];

   // next register contents; reserved bits are not stored
   assign cv_d = wr_volt ? reg_wdata[ccr_pkg::CV_MSB:ccr_pkg::CV_LSB] : cv_q;
   assign susp_d = wr_volt ? reg_wdata[ccr_pkg::SUSPEND_BIT] : susp_q;
   assign tcv_d = wr_temp ? reg_wdata[ccr_pkg::CV_MSB:ccr_pkg::CV_LSB] : tcv_q;
   assign scale_d = wr_mon ? reg_wdata[ccr_pkg::SCALE_MSB:ccr_pkg::SCALE_LSB] : scale_q;
   assign sel_d = wr_mon ? reg_wdata[ccr_pkg::SEL_MSB:ccr_pkg::SEL_LSB] : sel_q;

   // read data mux, reserved bits read zero, unmapped reads zero
   always_comb begin
      rdata_d = rdata_q;
      if (reg_rd) begin
         if (reg_addr == ccr_pkg::ADDR_CHG_VOLT) begin
            rdata_d = {cv_q, susp_q, 1'b0};
         end else if (reg_addr == ccr_pkg::ADDR_TEMP_VOLT) begin
            rdata_d = {tcv_q, 2'b00};
         end else if (reg_addr == ccr_pkg::ADDR_MON_CFG) begin
            rdata_d = {scale_q, sel_q};
         end else begin
            rdata_d = 8'h00;
         end
      end
   end

   // effective values derived from the stored fields
   wire [5:0] cv_pick = temp_norm_s ? cv_q : tcv_q;
   wire [5:0] cv_sat = (cv_pick >= ccr_pkg::CV_SAT) ? ccr_pkg::CV_SAT : cv_pick;
   wire [3:0] scale_sat = (scale_q >= ccr_pkg::SCALE_SAT) ? ccr_pkg::SCALE_SAT : scale_q;
   wire [ccr_pkg::NUM_CHAN-1:0] chan_dec;
   wire mux_on = res_on_s && (sel_q != ccr_pkg::SEL_OFF);

   ccr_mux_decode u_dec (
      .sel(sel_q),
      .chan(chan_dec)
   );

   // stored fields
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cv_q <= ccr_pkg::CV_RESET;
         tcv_q <= ccr_pkg::TEMP_CV_RESET;
         susp_q <= ccr_pkg::SUSPEND_RESET;
         scale_q <= ccr_pkg::SCALE_RESET;
         sel_q <= ccr_pkg::SEL_RESET;
         rdata_q <= 8'h00;
      end else begin
         cv_q <= cv_d;
         tcv_q <= tcv_d;
         susp_q <= susp_d;
         scale_q <= scale_d;
         sel_q <= sel_d;
         rdata_q <= rdata_d;
      end
   end

   // two stage synchronisers for the outside status levels
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
      end else begin
         sync1_q <= {resource_on, charging_flag, temp_normal};
         sync2_q <= sync1_q;
      end
   end

   // suspend side effects: irq pulse on the rising edge, detail forced to zero
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
         draw_q <= 1'b1;
         det_q <= 1'b0;
      end else begin
         irq_q <= susp_d && !susp_q;
         draw_q <= !susp_d;
         det_q <= susp_d;
      end
   end

   // registered charger and monitor controls
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         eff_cv_q <= ccr_pkg::CV_RESET;
         scale_eff_q <= ccr_pkg::SCALE_SAT;
         chan_q <= '0;
         oe_n_q <= 1'b1;
         chg_valid_q <= 1'b0;
      end else begin
         eff_cv_q <= cv_sat;
         scale_eff_q <= scale_sat;
         chan_q <= mux_on ? chan_dec : '0;
         oe_n_q <= !mux_on;
         chg_valid_q <= mux_on && chan_dec[ccr_pkg::CHAN_CHG_I] && charging_s;
      end
   end

   // output wiring
   assign reg_rdata = rdata_q;
   assign battery_target_voltage_code = eff_cv_q;
   assign input_suspend = susp_q;
   assign input_draw_en = draw_q;
   assign input_change_irq = irq_q;
   assign input_detail_clear = det_q;
   assign discharge_monitor_full_scale = scale_eff_q;
   assign monitor_chan_en = chan_q;
   assign monitor_output_oe_n = oe_n_q;
   assign monitor_chg_valid = chg_valid_q;

   // checks
   a_suspend_irq_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(susp_q) |-> irq_q && det_q) else $error("suspend rise without irq or detail clear");
   a_suspend_no_draw: assert property (@(posedge core_clk) disable iff (!rst_n)
      susp_q |-> !draw_q) else $error("input draws current while suspended");
   a_cv_normal_pick: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(temp_norm_s) && $past(cv_q) < 6'h28 |-> eff_cv_q == $past(cv_q))
      else $error("normal temperature target not from first register");
   a_cv_temp_pick: assert property (@(posedge core_clk) disable iff (!rst_n)
      !$past(temp_norm_s) && $past(tcv_q) >= 6'h28 |-> eff_cv_q == 6'h28)
      else $error("adjusted target not saturated");
   a_cv_saturate: assert property (@(posedge core_clk) disable iff (!rst_n)
      eff_cv_q <= 6'h28) else $error("voltage code above saturation");
   a_scale_saturate: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(scale_q) >= 4'hA |-> scale_eff_q == 4'hA) else $error("full scale not saturated");
   a_mux_off_float: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(sel_q) == 4'h0 |-> oe_n_q && chan_q == '0) else $error("monitor driven while disabled");
   a_resource_off_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      !$past(res_on_s) |-> oe_n_q && !chg_valid_q) else $error("monitor active outside resource on");
   a_chg_valid_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
      chg_valid_q |-> chan_q[3] && $past(charging_s)) else $error("charge reading valid without charging");
   a_sys_channel_fold: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(res_on_s) && $past(sel_q) >= 4'hA |-> chan_q == 10'h200) else $error("upper code not system channel");
   a_reset_values: assert property (@(posedge core_clk)
      $past(!rst_n) |-> cv_q == 6'h00 && tcv_q == 6'h00 && scale_q == 4'hF && sel_q == 4'h0)
      else $error("reset values wrong");

   // side effect, saturation, decode and readback checks
   a_irq_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
      irq_q |=> !irq_q) else $error("input change irq longer than one cycle");
   a_detail_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
      det_q == susp_q) else $error("detail clear does not follow suspend");
   a_draw_when_free: assert property (@(posedge core_clk) disable iff (!rst_n)
      !susp_q |-> draw_q) else $error("input draw blocked without suspend");
   a_cv_normal_sat: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(temp_norm_s) && $past(cv_q) >= ccr_pkg::CV_SAT |-> eff_cv_q == ccr_pkg::CV_SAT)
      else $error("normal target not saturated");
   a_cv_temp_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
      !$past(temp_norm_s) && $past(tcv_q) < ccr_pkg::CV_SAT |-> eff_cv_q == $past(tcv_q))
      else $error("adjusted target not passed through");
   a_scale_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(scale_q) < ccr_pkg::SCALE_SAT |-> scale_eff_q == $past(scale_q))
      else $error("full scale code altered below saturation");
   a_chan_one_hot: assert property (@(posedge core_clk) disable iff (!rst_n)
      $onehot0(chan_q)) else $error("more than one monitor channel enabled");
   a_chan_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(res_on_s) && $past(sel_q) != ccr_pkg::SEL_OFF && $past(sel_q) < ccr_pkg::SEL_SYS_FIRST
      |-> chan_q == (10'h001 << ($past(sel_q) - 4'h1)))
      else $error("monitor channel not decoded from selector");
   a_oe_needs_chan: assert property (@(posedge core_clk) disable iff (!rst_n)
      !oe_n_q |-> chan_q != '0) else $error("monitor output driven with no channel");
   a_reserved_read_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(reg_rd) && $past(reg_addr) == ccr_pkg::ADDR_TEMP_VOLT |-> rdata_q[1:0] == 2'b00)
      else $error("reserved bits of adjusted target read nonzero");
endmodule : ccr_regs

//--- tb/tb.sv
// self-checking testbench for the charger configuration register bank
`timescale 1ns/1ps
module tb;
   // design stimulus and observed outputs
   logic core_clk, rst_n, reg_wr, reg_rd, temp_normal, charging_flag, resource_on;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
   logic [5:0] code;
   logic suspend, draw_en, irq, detail_clear, oe_n, chg_valid;
   logic [3:0] full_scale;
   logic [9:0] chan_en, exp_chan;
   int mismatches, comparisons, cycles, irq_count;

   ccr_regs u_ccr_regs (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .temp_normal(temp_normal),
      .charging_flag(charging_flag), .resource_on(resource_on), .battery_target_voltage_code(code),
      .input_suspend(suspend), .input_draw_en(draw_en), .input_change_irq(irq),
      .input_detail_clear(detail_clear), .discharge_monitor_full_scale(full_scale),
      .monitor_chan_en(chan_en), .monitor_output_oe_n(oe_n), .monitor_chg_valid(chg_valid));

   // free-running 40 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // interrupt pulses counted on the falling edge, where the output has settled
   always @(negedge core_clk) begin
      if (irq === 1'b1) irq_count++;
   end

   // cycle ceiling
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic check_val(input logic [9:0] got, input logic [9:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_val

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask : wait_cyc

   // one-cycle write strobe, then an idle edge so a following call never retoggles it at once
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
      @(negedge core_clk);
   endtask : reg_write

   // read strobe, data taken once it has settled
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
   endtask : reg_read

   task automatic test_reset;
      reg_read(ccr_pkg::ADDR_CHG_VOLT, rd_val);
      check_val(10'(rd_val), 10'h000);
      reg_read(ccr_pkg::ADDR_TEMP_VOLT, rd_val);
      check_val(10'(rd_val), 10'h000);
      reg_read(ccr_pkg::ADDR_MON_CFG, rd_val);
      check_val(10'(rd_val), 10'h0F0);
      check_val(10'(full_scale), 10'h00A);
      check_val(chan_en, 10'h000);
      check_val(10'(oe_n), 10'h001);
      check_val(10'({draw_en, code}), 10'h040);
   endtask : test_reset

   task automatic test_suspend;
      int base;
      base = irq_count;
      reg_write(ccr_pkg::ADDR_CHG_VOLT, 8'h02);
      wait_cyc(4);
      check_val(10'(irq_count - base), 10'h001);
      check_val(10'({suspend, draw_en, detail_clear}), 10'h005);
      reg_read(ccr_pkg::ADDR_CHG_VOLT, rd_val);
      check_val(10'(rd_val), 10'h002);
      reg_write(ccr_pkg::ADDR_CHG_VOLT, 8'h02);
      wait_cyc(4);
      check_val(10'(irq_count - base), 10'h001);
      reg_write(ccr_pkg::ADDR_CHG_VOLT, 8'h00);
      wait_cyc(4);
      check_val(10'({suspend, draw_en, detail_clear}), 10'h002);
   endtask : test_suspend

   task automatic test_voltage;
      reg_write(ccr_pkg::ADDR_CHG_VOLT, 8'hFC);
      reg_write(ccr_pkg::ADDR_TEMP_VOLT, 8'h14);
      reg_write(8'h29, 8'hFF);
      reg_read(ccr_pkg::ADDR_CHG_VOLT, rd_val);
      check_val(10'(rd_val), 10'h0FC);
      reg_read(ccr_pkg::ADDR_TEMP_VOLT, rd_val);
      check_val(10'(rd_val), 10'h014);
      reg_read(8'h29, rd_val);
      check_val(10'(rd_val), 10'h000);
      wait_cyc(2);
      check_val(10'(code), 10'h028);
      temp_normal = 1'b0;
      wait_cyc(5);
      check_val(10'(code), 10'h005);
      reg_write(ccr_pkg::ADDR_TEMP_VOLT, 8'hA0);
      wait_cyc(3);
      check_val(10'(code), 10'h028);
      reg_write(ccr_pkg::ADDR_CHG_VOLT, 8'h9C);
      temp_normal = 1'b1;
      wait_cyc(5);
      check_val(10'(code), 10'h027);
   endtask : test_voltage

   task automatic test_scale;
      for (int i = 0; i < 16; i++) begin
         reg_write(ccr_pkg::ADDR_MON_CFG, {i[3:0], 4'h0});
         wait_cyc(4);
         check_val(10'(full_scale), (i > 9) ? 10'h00A : 10'(i));
      end
   endtask : test_scale

   task automatic test_mux;
      resource_on = 1'b1;
      charging_flag = 1'b1;
      wait_cyc(5);
      for (int s = 0; s < 16; s++) begin
         exp_chan = (s == 0) ? 10'h000 : (s > 9) ? 10'h200 : 10'h001 << (s - 1);
         reg_write(ccr_pkg::ADDR_MON_CFG, {4'h0, s[3:0]});
         wait_cyc(4);
         check_val(chan_en, exp_chan);
         check_val(10'(oe_n), (s == 0) ? 10'h001 : 10'h000);
         check_val(10'(chg_valid), (s == 4) ? 10'h001 : 10'h000);
      end
      reg_write(ccr_pkg::ADDR_MON_CFG, 8'h04);
      charging_flag = 1'b0;
      wait_cyc(5);
      check_val(10'(chg_valid), 10'h000);
      check_val(chan_en, 10'h008);
      charging_flag = 1'b1;
      resource_on = 1'b0;
      wait_cyc(5);
      check_val(10'({oe_n, chg_valid}), 10'h002);
      check_val(chan_en, 10'h000);
      reg_write(ccr_pkg::ADDR_MON_CFG, 8'h00);
      reg_read(ccr_pkg::ADDR_MON_CFG, rd_val);
      check_val(10'(rd_val), 10'h000);
   endtask : test_mux

   task automatic finish_test;
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test

   // main sequence, inputs change on the falling edge
   initial begin
      rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
      temp_normal = 1'b1; charging_flag = 1'b0; resource_on = 1'b0;
      mismatches = 0; comparisons = 0; cycles = 0; irq_count = 0;
      wait_cyc(6);
      rst_n = 1'b1;
      wait_cyc(1);
      test_reset();
      test_suspend();
      test_voltage();
      test_scale();
      test_mux();
      finish_test();
   end
endmodule : tb
